// >>> agcc_consts.vh
`ifndef AGCC_CONSTS_VH
`define AGCC_CONSTS_VH
// register indices; the byte address is four times the index
`define AGCC_IX_SATCNT 6'h20
`define AGCC_IX_PAD 6'h22
`define AGCC_IX_HISAT 6'h24
`define AGCC_IX_LOCKIN 6'h26
`define AGCC_IX_WINPOS 6'h28
`define AGCC_IX_BACKOFF 6'h2a
`define AGCC_IX_TBLADDR 6'h2c
`define AGCC_IX_TBLDATA 6'h2e
`define AGCC_IX_LGAIN 6'h30
`define AGCC_IX_MANUAL 6'h32
`define AGCC_IX_TEST 6'h34
`define AGCC_IX_RFTHR 6'h36
`define AGCC_IX_MIDLOW 6'h38
`define AGCC_IX_WINNEG 6'h3a
`define AGCC_IX_STATUS 6'h3c
// storage slots behind the indices
`define AGCC_NSLOT 14
`define AGCC_S_SATCNT 4'h0
`define AGCC_S_PAD 4'h1
`define AGCC_S_HISAT 4'h2
`define AGCC_S_LOCKIN 4'h3
`define AGCC_S_WINPOS 4'h4
`define AGCC_S_BACKOFF 4'h5
`define AGCC_S_TBLADDR 4'h6
`define AGCC_S_TBLDATA 4'h7
`define AGCC_S_LGAIN 4'h8
`define AGCC_S_MANUAL 4'h9
`define AGCC_S_TEST 4'ha
`define AGCC_S_RFTHR 4'hb
`define AGCC_S_MIDLOW 4'hc
`define AGCC_S_WINNEG 4'hd
`define AGCC_S_STATUS 4'he
`define AGCC_S_NONE 4'hf
// single-bit fields
`define AGCC_TM_CONT 7
`define AGCC_TM_POL 6
`define AGCC_TM_XDIS 5
`define AGCC_TM_OVR 2
`define AGCC_TM_ABORT 1
`define AGCC_TM_SATEN 0
`define AGCC_RFT_DIS 7
`define AGCC_TA_RDSEL 5
`define AGCC_MAN_RF 7
// reset values
`define AGCC_RST_PAD 8'h1e
`define AGCC_RST_LGAIN 8'h2d
`define AGCC_RST_ZERO 8'h00
// loop gain of 1.0 is 1 << this
`define AGCC_LG_SHIFT 6
`define AGCC_ATT_MAX 10'sh07f
`define AGCC_CW_ON 3'h0
`define AGCC_CW_OFF 3'h7
`define AGCC_RESP_OKAY 2'h0
`define AGCC_RESP_SLVERR 2'h2
`endif

// >>> agcc_control.v
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "agcc_consts.vh"
// Function
// R01 - six-bit rf pad value used in rssi
// R02 - high sat step is twice high value
// R03 - high sat count in low nibble
// R04 - cw scale field; zero on, max off
// R05 - five-bit inner lock-in window
// R06 - antenna search needs updates at most max
// R07 - positive outer lock window, half units
// R08 - six-bit adc backoff in half dB
// R09 - read select returns table entry at address
// R10 - table entries seven-bit unsigned, low bits
// R11 - seven-bit fractional loop gain per update
// R12 - manual rf bit drives pad, polarity inverts
// R13 - override feeds manual if value out
// R14 - continuous bit keeps updating through freeze, lock
// R15 - one extra update after lock unless disabled
// R16 - override stops loop, drives both lines
// R17 - power abort ends second antenna search
// R18 - sat step bit enables step in window
// R19 - pad removed below threshold unless disabled
// R20 - mid step twice mid, low step low
// R21 - block level 4.0 to 7.5 dB
// R22 - negative window programmed positive, negated inside
// R23 - separate mid and low sat counts
// R24 - unused bits store and read back
module agcc_control (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire update_tick,
    input wire agc_restart,
    input wire agc_freeze,
    input wire signed [7:0] level_err,
    input wire [7:0] sat_count,
    input wire [6:0] rssi_raw,
    input wire on_second_ant,
    input wire [6:0] ant1_power,
    input wire [6:0] ant2_power,
    output wire rf_pad_control_line,
    output wire [6:0] if_gain_line,
    output wire [7:0] rssi,
    output wire [5:0] adc_backoff,
    output wire [2:0] cw_scale,
    output wire cw_force_on,
    output wire cw_force_off,
    output wire gain_locked,
    output wire antenna_search_ok,
    output wire second_ant_abort,
    output wire ant_dwell_done
);

// ----------------------------------------
// address decode
// ----------------------------------------
// maps a byte address to a storage slot
function [3:0] slot_of;
    input [7:0] a;
    begin
        slot_of = `AGCC_S_NONE;
        if (a[1:0] != 2'h0) begin
            slot_of = `AGCC_S_NONE;
        end else if (a[7:2] == `AGCC_IX_SATCNT) begin
            slot_of = `AGCC_S_SATCNT;
        end else if (a[7:2] == `AGCC_IX_PAD) begin
            slot_of = `AGCC_S_PAD;
        end else if (a[7:2] == `AGCC_IX_HISAT) begin
            slot_of = `AGCC_S_HISAT;
        end else if (a[7:2] == `AGCC_IX_LOCKIN) begin
            slot_of = `AGCC_S_LOCKIN;
        end else if (a[7:2] == `AGCC_IX_WINPOS) begin
            slot_of = `AGCC_S_WINPOS;
        end else if (a[7:2] == `AGCC_IX_BACKOFF) begin
            slot_of = `AGCC_S_BACKOFF;
        end else if (a[7:2] == `AGCC_IX_TBLADDR) begin
            slot_of = `AGCC_S_TBLADDR;
        end else if (a[7:2] == `AGCC_IX_TBLDATA) begin
            slot_of = `AGCC_S_TBLDATA;
        end else if (a[7:2] == `AGCC_IX_LGAIN) begin
            slot_of = `AGCC_S_LGAIN;
        end else if (a[7:2] == `AGCC_IX_MANUAL) begin
            slot_of = `AGCC_S_MANUAL;
        end else if (a[7:2] == `AGCC_IX_TEST) begin
            slot_of = `AGCC_S_TEST;
        end else if (a[7:2] == `AGCC_IX_RFTHR) begin
            slot_of = `AGCC_S_RFTHR;
        end else if (a[7:2] == `AGCC_IX_MIDLOW) begin
            slot_of = `AGCC_S_MIDLOW;
        end else if (a[7:2] == `AGCC_IX_WINNEG) begin
            slot_of = `AGCC_S_WINNEG;
        end else if (a[7:2] == `AGCC_IX_STATUS) begin
            slot_of = `AGCC_S_STATUS;
        end
    end
endfunction

// ----------------------------------------
// storage
// ----------------------------------------
reg [7:0] cfg_q [0:`AGCC_NSLOT-1];
reg [6:0] tbl_q [0:31];
reg aw_full_q;
reg [7:0] awaddr_q;
reg w_full_q;
reg [7:0] wdata_q;
reg wlane_q;
reg bvalid_q;
reg [1:0] bresp_q;
reg rvalid_q;
reg [7:0] rdata_q;
reg [1:0] rresp_q;
reg [9:0] att_q;
reg locked_q;
reg extra_q;
reg [3:0] upd_cnt_q;
reg rf_line_q;
reg [6:0] if_gain_q;
reg [7:0] rssi_q;

// ----------------------------------------
// axi write channel
// ----------------------------------------
wire aw_hs = s_axi_awvalid & s_axi_awready;
wire w_hs = s_axi_wvalid & s_axi_wready;
wire wr_go = aw_full_q & w_full_q;
wire [3:0] wslot = slot_of(awaddr_q);
// writes only land through byte lane 0
wire wr_en = wr_go & wlane_q;
assign s_axi_awready = ~aw_full_q & ~bvalid_q;
assign s_axi_wready = ~w_full_q & ~bvalid_q;
assign s_axi_bvalid = bvalid_q;
assign s_axi_bresp = bresp_q;

// address and data are caught in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_full_q <= 1'b0;
        awaddr_q <= 8'h00;
        w_full_q <= 1'b0;
        wdata_q <= 8'h00;
        wlane_q <= 1'b0;
        bvalid_q <= 1'b0;
        bresp_q <= `AGCC_RESP_OKAY;
    end else begin
        if (aw_hs) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        if (w_hs) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
        end
        if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            // status is read only, unmapped is refused
            if (wslot == `AGCC_S_NONE) begin
                bresp_q <= `AGCC_RESP_SLVERR;
            end else begin
                bresp_q <= `AGCC_RESP_OKAY;
            end
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
end

// every bit of each slot stores what was written
genvar g;
generate
    for (g = 0; g < `AGCC_NSLOT; g = g + 1) begin : slot_gen
        always @(posedge aclk) begin
            if (!aresetn) begin
                cfg_q[g] <= (g == `AGCC_S_PAD) ? `AGCC_RST_PAD :
                            (g == `AGCC_S_LGAIN) ? `AGCC_RST_LGAIN :
                            `AGCC_RST_ZERO;
            end else if (wr_en && wslot == g) begin
                cfg_q[g] <= wdata_q; // [R24]
            end
        end
    end
    // table entry taken from a data write at the held address
    for (g = 0; g < 32; g = g + 1) begin : tbl_gen
        always @(posedge aclk) begin
            if (!aresetn) begin
                tbl_q[g] <= 7'h00;
            end else if (wr_en && wslot == `AGCC_S_TBLDATA
                         && cfg_q[`AGCC_S_TBLADDR][4:0] == g) begin
                tbl_q[g] <= wdata_q[6:0]; // [R10]
            end
        end
    end
endgenerate

// ----------------------------------------
// field views
// ----------------------------------------
wire [3:0] mid_cnt = cfg_q[`AGCC_S_SATCNT][7:4]; // [R23]
wire [3:0] low_cnt = cfg_q[`AGCC_S_SATCNT][3:0]; // [R23]
wire [5:0] pad_val = cfg_q[`AGCC_S_PAD][5:0]; // [R01]
wire [3:0] hi_val = cfg_q[`AGCC_S_HISAT][7:4];
wire [3:0] hi_cnt = cfg_q[`AGCC_S_HISAT][3:0]; // [R03]
wire [4:0] lockin = cfg_q[`AGCC_S_LOCKIN][4:0]; // [R05]
wire [2:0] max_lock = cfg_q[`AGCC_S_WINPOS][7:5];
wire [4:0] win_pos = cfg_q[`AGCC_S_WINPOS][4:0]; // [R07]
wire [4:0] tbl_addr = cfg_q[`AGCC_S_TBLADDR][4:0];
wire tbl_rdsel = cfg_q[`AGCC_S_TBLADDR][`AGCC_TA_RDSEL];
wire [6:0] lgain = cfg_q[`AGCC_S_LGAIN][6:0]; // [R11]
wire [7:0] manual = cfg_q[`AGCC_S_MANUAL];
wire [7:0] test = cfg_q[`AGCC_S_TEST];
wire [6:0] rf_thr = cfg_q[`AGCC_S_RFTHR][6:0];
wire rf_thr_dis = cfg_q[`AGCC_S_RFTHR][`AGCC_RFT_DIS];
wire [3:0] mid_val = cfg_q[`AGCC_S_MIDLOW][7:4];
wire [3:0] low_val = cfg_q[`AGCC_S_MIDLOW][3:0];
wire [2:0] blk_lvl = cfg_q[`AGCC_S_WINNEG][7:5];
wire [4:0] win_neg = cfg_q[`AGCC_S_WINNEG][4:0];
wire ovr = test[`AGCC_TM_OVR];
wire pol = test[`AGCC_TM_POL];

// ----------------------------------------
// gain loop
// ----------------------------------------
// level error is in half dB, positive means too strong
wire signed [9:0] err = {{2{level_err[7]}}, level_err};
// inner window is in quarter dB, so compare twice the error
wire signed [9:0] err_x2 = {err[8:0], 1'b0};
wire signed [9:0] inner = {5'h00, lockin};
wire in_inner = (err_x2 <= inner) && (err_x2 >= -inner); // [R05]
// negative side held as magnitude and negated here
wire signed [9:0] out_hi = {5'h00, win_pos}; // [R07]
wire signed [9:0] out_lo = -$signed({5'h00, win_neg}); // [R22]
wire in_outer = (err <= out_hi) && (err >= out_lo);
// block level reads as 1xx.x, i.e. 8 to 15 half dB
wire signed [9:0] blk = {6'h00, 1'b1, blk_lvl}; // [R21]
wire sat_block = ~test[`AGCC_TM_SATEN] && (err <= blk); // [R18]
// saturation step, highest band that is exceeded wins
reg [4:0] sat_step;
always @* begin
    sat_step = 5'h00;
    if (sat_count > {4'h0, hi_cnt}) begin
        sat_step = {hi_val, 1'b0}; // [R02]
    end else if (sat_count > {4'h0, mid_cnt}) begin
        sat_step = {mid_val, 1'b0}; // [R20]
    end else if (sat_count > {4'h0, low_cnt}) begin
        sat_step = {1'b0, low_val}; // [R20]
    end
    if (sat_block) begin
        sat_step = 5'h00; // [R18]
    end
end
// proportional step: error times fractional gain
wire signed [17:0] prod = err * $signed({1'b0, lgain}); // [R11]
wire signed [17:0] delta = prod >>> `AGCC_LG_SHIFT;
wire signed [9:0] att_sum = $signed(att_q) + delta[9:0]
                            + $signed({5'h00, sat_step});
// accumulator clipped to 0..127
wire signed [9:0] att_nx = (att_sum < 10'sh000) ? 10'sh000 :
                           (att_sum > `AGCC_ATT_MAX) ?
                           `AGCC_ATT_MAX : att_sum;
// updates stop in freeze or lock unless continuous
wire hold = (agc_freeze | (locked_q & ~extra_q))
            & ~test[`AGCC_TM_CONT]; // [R14]
wire upd = update_tick & ~ovr & ~hold; // [R16]
// accumulator, lock state and update counter
always @(posedge aclk) begin
    if (!aresetn) begin
        att_q <= 10'h000;
        locked_q <= 1'b0;
        extra_q <= 1'b0;
        upd_cnt_q <= 4'h0;
    end else if (agc_restart) begin
        locked_q <= 1'b0;
        extra_q <= 1'b0;
        upd_cnt_q <= 4'h0;
    end else if (upd) begin
        att_q <= att_nx;
        if (!locked_q && upd_cnt_q != 4'hf) begin
            upd_cnt_q <= upd_cnt_q + 4'h1;
        end
        if (!locked_q && in_inner) begin
            locked_q <= 1'b1;
            extra_q <= ~test[`AGCC_TM_XDIS]; // [R15]
        end else begin
            // the extra pass is spent on the next update
            extra_q <= 1'b0; // [R15]
            if (locked_q && !in_outer) begin
                locked_q <= 1'b0;
            end
        end
    end
end

// ----------------------------------------
// analog drive
// ----------------------------------------
wire [6:0] if_auto = tbl_q[att_q[6:2]];
// pad removed when gain code drops under the threshold
wire pad_off = ~rf_thr_dis & (if_auto < rf_thr); // [R19]
wire pad_in = ~(ovr ? manual[`AGCC_MAN_RF] : pad_off);

// registered outputs to the rf and if stages
always @(posedge aclk) begin
    if (!aresetn) begin
        rf_line_q <= 1'b0;
        if_gain_q <= 7'h00;
        rssi_q <= 8'h00;
    end else begin
        if (ovr) begin
            rf_line_q <= manual[`AGCC_MAN_RF] ^ pol; // [R12] [R16]
            if_gain_q <= manual[6:0]; // [R13]
        end else begin
            rf_line_q <= pad_off ^ pol; // [R19]
            if_gain_q <= if_auto;
        end
        // the pad only counts while it is inserted
        rssi_q <= {1'b0, rssi_raw}
                  + (pad_in ? {2'h0, pad_val} : 8'h00); // [R01]
    end
end
assign rf_pad_control_line = rf_line_q;
assign if_gain_line = if_gain_q;
assign rssi = rssi_q;
assign adc_backoff = cfg_q[`AGCC_S_BACKOFF][5:0]; // [R08]
assign cw_scale = cfg_q[`AGCC_S_LOCKIN][7:5]; // [R04]
assign cw_force_on = cw_scale == `AGCC_CW_ON; // [R04]
assign cw_force_off = cw_scale == `AGCC_CW_OFF; // [R04]
assign gain_locked = locked_q;
assign antenna_search_ok = locked_q
                           & (upd_cnt_q <= {1'b0, max_lock}); // [R06]
assign second_ant_abort = test[`AGCC_TM_ABORT] & on_second_ant
                          & (ant2_power < ant1_power); // [R17]
assign ant_dwell_done = second_ant_abort
                        | (on_second_ant & locked_q); // [R17]

// ----------------------------------------
// axi read channel
// ----------------------------------------
wire [3:0] rslot = slot_of(s_axi_araddr);
wire [7:0] status = {locked_q, antenna_search_ok, extra_q,
                     ant_dwell_done, upd_cnt_q};
// read mux; table data may show the table instead
reg [7:0] rd_val;
always @* begin
    rd_val = 8'h00;
    if (rslot == `AGCC_S_STATUS) begin
        rd_val = status;
    end else if (rslot == `AGCC_S_TBLDATA && tbl_rdsel) begin
        rd_val = {1'b0, tbl_q[tbl_addr]}; // [R09]
    end else if (rslot != `AGCC_S_NONE) begin
        rd_val = cfg_q[rslot]; // [R09]
    end
end

assign s_axi_arready = ~rvalid_q;
assign s_axi_rvalid = rvalid_q;
assign s_axi_rdata = {24'h000000, rdata_q};
assign s_axi_rresp = rresp_q;
// one read at a time, answered the edge after the address
always @(posedge aclk) begin
    if (!aresetn) begin
        rvalid_q <= 1'b0;
        rdata_q <= 8'h00;
        rresp_q <= `AGCC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        if (rslot == `AGCC_S_NONE) begin
            rresp_q <= `AGCC_RESP_SLVERR;
        end else begin
            rresp_q <= `AGCC_RESP_OKAY;
        end
    end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
    end
end

endmodule

// >>> agcc_control_chk.sv
`timescale 1ns/10ps
// ------------------------------------------
// bus handshake and field relation checks
// ------------------------------------------
module agcc_control_chk (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire gain_locked,
    input wire [2:0] cw_scale,
    input wire cw_force_on,
    input wire cw_force_off,
    input wire on_second_ant,
    input wire [6:0] ant1_power,
    input wire [6:0] ant2_power,
    input wire second_ant_abort,
    input wire ant_dwell_done
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // a taken read address is answered on the next edge
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // no second read is accepted while one is answered
    a_rd_refuse: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    // write answered within three edges when both halves are taken in the same cycle
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    a_wr_refuse: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    // registers are one byte wide, upper lanes read zero
    a_rd_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read lanes not zero");
    // field zero forces on, all ones forces off
    a_cw_force: assert property (
        cw_force_on == (cw_scale == 3'h0) &&
        cw_force_off == (cw_scale == 3'h7))
        else $error("cw force flags wrong");
    // abort only when antenna two is weaker
    a_abort_cause: assert property (
        second_ant_abort |-> on_second_ant && ant2_power < ant1_power)
        else $error("abort without weaker antenna");
    a_abort_dwell: assert property (
        second_ant_abort |-> ant_dwell_done)
        else $error("abort did not end dwell");

    // main scenarios reached
    c_write: cover property (s_axi_bvalid);
    c_abort: cover property (second_ant_abort);
    c_cw_off: cover property (cw_force_off);
    c_lock: cover property (gain_locked);
endmodule

// >>> agcc_rf_model.sv
`timescale 1ns/10ps
// ------------------------------------------
// analog pad and if gain stage model
// ------------------------------------------
module agcc_rf_model (
    input wire aclk,
    input wire rf_pad_control_line,
    input wire [6:0] if_gain_line,
    input wire [6:0] sig_level,
    output reg [6:0] rssi_raw,
    output reg signed [7:0] level_err,
    output reg [7:0] sat_count
);
    // 30 dB pad sits in the path while the line is low
    wire [6:0] pad_db = rf_pad_control_line ? 7'h00 : 7'h1e;

    // sampled like a slow converter, one edge late
    always @(posedge aclk) begin
        rssi_raw <= sig_level - pad_db;
        level_err <= sig_level - pad_db - if_gain_line;
        sat_count <= (sig_level > 7'h5a) ? 8'h0f : 8'h00;
    end
endmodule

// >>> agcc_control_bench.sv
`timescale 1ns/10ps
`include "agcc_consts.vh"
module agcc_control_bench;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [7:0] s_axi_awaddr = 8'h00;
    reg [2:0] s_axi_awprot = 3'h0;
    reg s_axi_awvalid = 1'b0;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_wvalid = 1'b0;
    reg s_axi_bready = 1'b0;
    reg [7:0] s_axi_araddr = 8'h00;
    reg [2:0] s_axi_arprot = 3'h0;
    reg s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0;
    reg update_tick = 1'b0;
    reg agc_restart = 1'b0;
    reg agc_freeze = 1'b0;
    reg on_second_ant = 1'b0;
    reg [6:0] ant1_power = 7'h00;
    reg [6:0] ant2_power = 7'h00;
    reg [6:0] sig_level = 7'h50;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire signed [7:0] level_err;
    wire [7:0] sat_count, rssi;
    wire [6:0] rssi_raw, if_gain_line;
    wire [5:0] adc_backoff;
    wire [2:0] cw_scale;
    wire rf_pad_control_line, cw_force_on, cw_force_off, gain_locked;
    wire antenna_search_ok, second_ant_abort, ant_dwell_done;
    integer miscompares = 0;
    integer tests_run = 0;
    integer i;
    reg [5:0] ix;

    agcc_control uut (.*);
    agcc_rf_model far_end (.*);

    // ------------------------------------------
    // clock and shared bus tasks
    // ------------------------------------------
    always #4 aclk = ~aclk;

    task chk(input string what, input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("Error %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // ready sampled at the falling edge, stable until the next rise
    task wr(input [5:0] a, input [7:0] d, input [1:0] er = 2'h0);
        reg ta, tw;
        begin
            @(posedge aclk);
            s_axi_awaddr <= {a, 2'b00};
            s_axi_wdata <= {24'h000000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            ta = 1'b0;
            tw = 1'b0;
            while (!ta || !tw) begin
                @(negedge aclk);
                if (s_axi_awvalid && s_axi_awready) ta = 1'b1;
                if (s_axi_wvalid && s_axi_wready) tw = 1'b1;
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
            end
            @(negedge aclk);
            while (s_axi_bvalid !== 1'b1) @(negedge aclk);
            chk("bresp", s_axi_bresp, er);
            @(posedge aclk);
            s_axi_bready <= 1'b0;
        end
    endtask

    task rd(input [5:0] a, input [7:0] exp, input [1:0] er = 2'h0);
        begin
            @(posedge aclk);
            s_axi_araddr <= {a, 2'b00};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            @(negedge aclk);
            while (s_axi_arready !== 1'b1) @(negedge aclk);
            @(posedge aclk);
            s_axi_arvalid <= 1'b0;
            @(negedge aclk);
            while (s_axi_rvalid !== 1'b1) @(negedge aclk);
            chk("rresp", s_axi_rresp, er);
            if (er == 2'h0) chk("rdata", s_axi_rdata, exp);
            @(posedge aclk);
            s_axi_rready <= 1'b0;
        end
    endtask

    // one update strobe, looked at half a cycle after it is taken
    task tick;
        begin
            @(posedge aclk);
            update_tick <= 1'b1;
            @(posedge aclk);
            update_tick <= 1'b0;
            @(negedge aclk);
        end
    endtask

    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task t_regs;
        begin
            rd(`AGCC_IX_PAD, `AGCC_RST_PAD);
            rd(`AGCC_IX_LGAIN, `AGCC_RST_LGAIN);
            // every register from pad to negative window keeps all eight bits, spare ones too
            for (i = 0; i < 13; i = i + 1) begin
                ix = 6'h22 + 6'(2 * i);
                wr(ix, 8'h5a);
                rd(ix, 8'h5a);
            end
            wr(`AGCC_IX_BACKOFF, 8'hff);
            rd(`AGCC_IX_BACKOFF, 8'hff);
            chk("adc_backoff", adc_backoff, 32'h3f);
            wr(6'h01, 8'h11, `AGCC_RESP_SLVERR);
            rd(6'h01, 8'h00, `AGCC_RESP_SLVERR);
            $display("test regs done");
        end
    endtask

    task t_ovr;
        begin
            wr(`AGCC_IX_MANUAL, 8'hd5);
            wr(`AGCC_IX_TEST, 8'h04);
            repeat (2) @(negedge aclk);
            chk("rf_pad", rf_pad_control_line, 32'h1);
            chk("if_gain", if_gain_line, 32'h55);
            wr(`AGCC_IX_TEST, 8'h44);
            repeat (2) @(negedge aclk);
            chk("rf_pad", rf_pad_control_line, 32'h0);
            chk("if_gain", if_gain_line, 32'h55);
            // pad inserted: strength adds the programmed pad back
            wr(`AGCC_IX_TEST, 8'h04);
            wr(`AGCC_IX_MANUAL, 8'h33);
            wr(`AGCC_IX_PAD, 8'h3f);
            repeat (4) @(negedge aclk);
            chk("rssi", rssi, sig_level - 32'h1e + 32'h3f);
            chk("if_gain", if_gain_line, 32'h33);
            wr(`AGCC_IX_TEST, 8'h00);
            $display("test override done");
        end
    endtask

    task t_tbl;
        begin
            wr(`AGCC_IX_TBLADDR, 8'h03);
            wr(`AGCC_IX_TBLDATA, 8'hff);
            rd(`AGCC_IX_TBLDATA, 8'hff);
            wr(`AGCC_IX_TBLADDR, 8'h23);
            rd(`AGCC_IX_TBLDATA, 8'h7f);
            wr(`AGCC_IX_TBLADDR, 8'h24);
            rd(`AGCC_IX_TBLDATA, 8'h00);
            $display("test table done");
        end
    endtask

    task t_cw;
        begin
            wr(`AGCC_IX_LOCKIN, 8'h00);
            chk("cw_on", cw_force_on, 32'h1);
            wr(`AGCC_IX_LOCKIN, 8'he0);
            chk("cw_off", cw_force_off, 32'h1);
            chk("cw_scale", cw_scale, 32'h7);
            wr(`AGCC_IX_LOCKIN, 8'h5f);
            chk("cw_scale", cw_scale, 32'h2);
            chk("cw_on", cw_force_on, 32'h0);
            $display("test cw done");
        end
    endtask

    task t_ant;
        begin
            wr(`AGCC_IX_TEST, 8'h02);
            @(posedge aclk);
            on_second_ant <= 1'b1;
            ant1_power <= 7'h40;
            ant2_power <= 7'h20;
            @(negedge aclk);
            chk("abort", second_ant_abort, 32'h1);
            chk("dwell", ant_dwell_done, 32'h1);
            @(posedge aclk);
            ant2_power <= 7'h50;
            @(negedge aclk);
            chk("abort", second_ant_abort, 32'h0);
            @(posedge aclk);
            ant2_power <= 7'h20;
            wr(`AGCC_IX_TEST, 8'h00);
            chk("abort", second_ant_abort, 32'h0);
            chk("dwell", ant_dwell_done, 32'h0);
            on_second_ant <= 1'b0;
            $display("test antenna done");
        end
    endtask

    task t_loop;
        begin
            // zero level error: the first free update locks
            @(posedge aclk);
            sig_level <= 7'h00;
            agc_freeze <= 1'b1;
            on_second_ant <= 1'b1;
            repeat (3) @(posedge aclk);
            tick;
            chk("frozen", gain_locked, 32'h0);
            @(posedge aclk);
            agc_freeze <= 1'b0;
            tick;
            chk("locked", gain_locked, 32'h1);
            chk("search_ok", antenna_search_ok, 32'h1);
            chk("dwell", ant_dwell_done, 32'h1);
            chk("rf_pad", rf_pad_control_line, 32'h1);
            rd(`AGCC_IX_STATUS, 8'hf1);
            tick;
            rd(`AGCC_IX_STATUS, 8'hd1);
            @(posedge aclk);
            agc_restart <= 1'b1;
            on_second_ant <= 1'b0;
            @(posedge aclk);
            agc_restart <= 1'b0;
            rd(`AGCC_IX_STATUS, 8'h00);
            // extra pass disabled: lock leaves nothing pending
            wr(`AGCC_IX_TEST, 8'h20);
            tick;
            rd(`AGCC_IX_STATUS, 8'hc1);
            wr(`AGCC_IX_TEST, 8'h00);
            $display("test loop done");
        end
    endtask

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_ovr;
        t_tbl;
        t_cw;
        t_ant;
        t_loop;
        finish_test;
    end

    // the whole run needs well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares = miscompares + 1;
        $display("watchdog expired");
        finish_test;
    end
endmodule

bind agcc_control agcc_control_chk chk_i (.*);
